/* File: wtad_pkg.sv */
package wtad_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register indices; the byte address is four times the index
    localparam logic [5:0] IDX_RSVD_A = 6'h2e;
    localparam logic [5:0] IDX_RSVD_B = 6'h2f;
    localparam logic [5:0] IDX_AUX = 6'h30;
    localparam logic [5:0] IDX_CTRL = 6'h31;
    localparam logic [5:0] IDX_CFG = 6'h32;
    localparam logic [5:0] IDX_REF = 6'h33;

    ////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [7:0] RST_AUX = 8'h00;
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [7:0] RST_CFG = 8'h00;
    localparam logic [7:0] RST_REF = 8'h00;
    localparam logic [7:0] RST_AVG = 8'h00;
    // bit 0 of the wake control is reserved and never stored
    localparam logic [7:0] CTRL_WR_MASK = 8'hfe;

    ////////////////////////////////////////////////////////////////////////////
    // wake control fields
    localparam int CTRL_RANGE_BIT = 7;
    localparam int CTRL_PERIOD_LSB = 4;
    localparam int CTRL_TMR_IRQ_BIT = 3;
    localparam int CTRL_AMP_CHK_BIT = 2;
    localparam int CTRL_PH_CHK_BIT = 1;

    // amplitude configuration fields
    localparam int CFG_THR_LSB = 4;
    localparam int CFG_INC_BIT = 3;
    localparam int CFG_WEIGHT_LSB = 1;
    localparam int CFG_SRC_BIT = 0;
    // a weight code of 0 divides by 4, i.e. a shift of 2
    localparam int AVG_SHIFT_BASE = 2;

    ////////////////////////////////////////////////////////////////////////////
    // timing
    localparam int CLK_HZ = 40_000_000;
    localparam int STEP_LONG_MS = 100;
    localparam int STEP_SHORT_MS = 10;
    localparam int STEP_LONG_CYC = STEP_LONG_MS * (CLK_HZ / 1000);
    localparam int STEP_SHORT_CYC = STEP_SHORT_MS * (CLK_HZ / 1000);

endpackage : wtad_pkg

/* File: wtad_top.sv */
`timescale 1ns/1ps
// What this block does
// RQ1 - range bit picks 100 ms or 10 ms
// RQ2 - period code gives one to eight steps
// RQ3 - timer interrupt on every expiry when enabled
// RQ4 - amplitude check on expiry, interrupt beyond threshold
// RQ5 - phase check on expiry, interrupt beyond threshold
// RQ6 - amplitude threshold sits in config bits 7:4
// RQ7 - include bit folds triggering result into average
// RQ8 - weight code selects 4, 8, 16, 32
// RQ9 - source bit picks written reference or average
// RQ10 - control, config, reference clear on defaults
// RQ11 - aux bit 7 shows selected channel
// RQ12 - aux bit 6 mirrors field detector
// RQ13 - aux bit 5 shows transmitter active
// RQ14 - aux bit 4 shows crystal stable
// RQ15 - aux bit 3 shows receive decoder enabled
// RQ16 - aux bit 2 shows message being received
// RQ17 - aux bit 1 shows peer detection mode
// RQ18 - aux bit 0 shows collision avoidance mode
// RQ19 - aux display reads zero after defaults
// RQ20 - average moves by difference over weight
// RQ21 - reserved locations read zero, ignore writes
module wtad_top #(
    parameter int LONG_STEP_CYCLES = wtad_pkg::STEP_LONG_CYC,
    parameter int SHORT_STEP_CYCLES = wtad_pkg::STEP_SHORT_CYC,
    parameter int CNT_W = 22
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic [7:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    input wire logic SET_DEFAULT,
    input wire logic SEL_PHASE_CHANNEL,
    input wire logic EXT_FIELD_DETECTED,
    input wire logic TX_ACTIVE,
    input wire logic OSC_STABLE,
    input wire logic RX_DECODER_ENABLED,
    input wire logic RX_RECEIVING,
    input wire logic PEER_DETECT_MODE,
    input wire logic COLLISION_AVOID_DETECT_ACTIVE,
    output logic AMP_MEAS_REQ,
    input wire logic AMP_MEAS_DONE,
    input wire logic [7:0] AMP_MEAS_RESULT,
    output logic PHASE_MEAS_REQ,
    input wire logic PHASE_MEAS_DONE,
    input wire logic [7:0] PHASE_MEAS_RESULT,
    input wire logic [3:0] PHASE_DELTA_THRESHOLD,
    input wire logic [7:0] PHASE_REFERENCE,
    output logic WAKE_IRQ_TIMER,
    output logic WAKE_IRQ_AMP,
    output logic WAKE_IRQ_PHASE,
    output logic [7:0] AMP_AVERAGE
);

    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] cfg;
        logic [7:0] amp_ref;
        logic [7:0] aux;
        logic [7:0] avg;
        logic waitreq;
        logic [7:0] rdata;
        logic [CNT_W-1:0] cyc;
        logic [2:0] step;
        logic amp_req;
        logic ph_req;
        logic irq_tmr;
        logic irq_amp;
        logic irq_ph;
    } wtad_state_t;

    wtad_state_t st_ff;
    wtad_state_t nxt_st;

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic at_reg(input logic [7:0] addr, input logic [5:0] idx);
        at_reg = (addr == {idx, 2'b00});
    endfunction : at_reg

    function automatic logic [7:0] abs_diff(input logic [7:0] a, input logic [7:0] b);
        abs_diff = (a >= b) ? (a - b) : (b - a);
    endfunction : abs_diff

    // avg + (res - avg) / weight, arithmetic shift keeps the sign of the step
    function automatic logic [7:0] avg_update(input logic [7:0] avg, input logic [7:0] res,
                                              input logic [1:0] wcode);
        logic signed [8:0] diff;
        logic signed [8:0] sum;
        diff = $signed({1'b0, res}) - $signed({1'b0, avg});
        sum = $signed({1'b0, avg}) + (diff >>> (wtad_pkg::AVG_SHIFT_BASE + int'(wcode)));
        avg_update = sum[7:0];
    endfunction : avg_update

    ////////////////////////////////////////////////////////////////////////////
    // decoded fields

    logic range_short;
    logic [2:0] period_code;
    logic [3:0] amp_thr;
    logic [1:0] amp_wcode;
    logic [CNT_W-1:0] base_last;
    logic timer_run;
    logic bus_acc;
    logic ctrl_wr;
    logic fire;
    logic [7:0] amp_refv;
    logic amp_trig;
    logic ph_trig;

    always_comb
    begin
        range_short = st_ff.ctrl[wtad_pkg::CTRL_RANGE_BIT];
        period_code = st_ff.ctrl[wtad_pkg::CTRL_PERIOD_LSB +: 3];
        // RQ6 threshold field
        amp_thr = st_ff.cfg[wtad_pkg::CFG_THR_LSB +: 4];
        // RQ8 weight code
        amp_wcode = st_ff.cfg[wtad_pkg::CFG_WEIGHT_LSB +: 2];
        // RQ1 base step
        base_last = range_short ? CNT_W'(SHORT_STEP_CYCLES - 1) : CNT_W'(LONG_STEP_CYCLES - 1);
        // the timer only runs when an expiry would do something
        timer_run = st_ff.ctrl[wtad_pkg::CTRL_TMR_IRQ_BIT] | st_ff.ctrl[wtad_pkg::CTRL_AMP_CHK_BIT]
                    | st_ff.ctrl[wtad_pkg::CTRL_PH_CHK_BIT];
        bus_acc = (AVS_READ | AVS_WRITE) & st_ff.waitreq;
        ctrl_wr = bus_acc & AVS_WRITE & AVS_BYTEENABLE[0] & at_reg(AVS_ADDRESS, wtad_pkg::IDX_CTRL);
        // RQ2 expiry after code plus one steps
        fire = timer_run & ~ctrl_wr & ~SET_DEFAULT & (st_ff.cyc == base_last)
               & (st_ff.step == period_code);
        // RQ9 reference source
        amp_refv = st_ff.cfg[wtad_pkg::CFG_SRC_BIT] ? st_ff.avg : st_ff.amp_ref;
        amp_trig = abs_diff(AMP_MEAS_RESULT, amp_refv) > {4'h0, amp_thr};
        ph_trig = abs_diff(PHASE_MEAS_RESULT, PHASE_REFERENCE) > {4'h0, PHASE_DELTA_THRESHOLD};
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.amp_req = 1'b0;
        nxt_st.ph_req = 1'b0;
        nxt_st.irq_tmr = 1'b0;
        nxt_st.irq_amp = 1'b0;
        nxt_st.irq_ph = 1'b0;

        // one wait cycle per access; waitrequest drops for exactly one cycle
        nxt_st.waitreq = ~bus_acc;
        if (bus_acc && AVS_READ)
        begin
            // RQ21 unmapped and reserved read zero
            nxt_st.rdata = 8'h00;
            if (at_reg(AVS_ADDRESS, wtad_pkg::IDX_AUX))
                nxt_st.rdata = st_ff.aux;
            else if (at_reg(AVS_ADDRESS, wtad_pkg::IDX_CTRL))
                nxt_st.rdata = st_ff.ctrl;
            else if (at_reg(AVS_ADDRESS, wtad_pkg::IDX_CFG))
                nxt_st.rdata = st_ff.cfg;
            else if (at_reg(AVS_ADDRESS, wtad_pkg::IDX_REF))
                nxt_st.rdata = st_ff.amp_ref;
        end
        if (bus_acc && AVS_WRITE && AVS_BYTEENABLE[0])
        begin
            // RQ21 reserved control bit dropped
            if (at_reg(AVS_ADDRESS, wtad_pkg::IDX_CTRL))
                nxt_st.ctrl = AVS_WRITEDATA[7:0] & wtad_pkg::CTRL_WR_MASK;
            else if (at_reg(AVS_ADDRESS, wtad_pkg::IDX_CFG))
                nxt_st.cfg = AVS_WRITEDATA[7:0];
            else if (at_reg(AVS_ADDRESS, wtad_pkg::IDX_REF))
                nxt_st.amp_ref = AVS_WRITEDATA[7:0];
        end

        // RQ1 step counting; a control write restarts the period
        if (!timer_run || ctrl_wr)
        begin
            nxt_st.cyc = '0;
            nxt_st.step = 3'h0;
        end
        else if (st_ff.cyc == base_last)
        begin
            nxt_st.cyc = '0;
            // RQ2 wrap after the coded step
            nxt_st.step = (st_ff.step == period_code) ? 3'h0 : st_ff.step + 3'h1;
        end
        else
        begin
            nxt_st.cyc = st_ff.cyc + CNT_W'(1);
        end

        if (fire)
        begin
            // RQ3 timer interrupt
            nxt_st.irq_tmr = st_ff.ctrl[wtad_pkg::CTRL_TMR_IRQ_BIT];
            // RQ4 amplitude trigger
            nxt_st.amp_req = st_ff.ctrl[wtad_pkg::CTRL_AMP_CHK_BIT];
            // RQ5 phase trigger
            nxt_st.ph_req = st_ff.ctrl[wtad_pkg::CTRL_PH_CHK_BIT];
        end

        // results are only judged while their check is enabled
        if (AMP_MEAS_DONE && st_ff.ctrl[wtad_pkg::CTRL_AMP_CHK_BIT])
        begin
            // RQ4 compare against threshold
            nxt_st.irq_amp = amp_trig;
            // RQ7 include or exclude triggering result
            if (!amp_trig || st_ff.cfg[wtad_pkg::CFG_INC_BIT])
                // RQ20 running average step
                nxt_st.avg = avg_update(st_ff.avg, AMP_MEAS_RESULT, amp_wcode);
        end
        if (PHASE_MEAS_DONE && st_ff.ctrl[wtad_pkg::CTRL_PH_CHK_BIT])
            // RQ5 phase compare
            nxt_st.irq_ph = ph_trig;

        // RQ11 RQ12 RQ13 RQ14 RQ15 RQ16 RQ17 RQ18 status snapshot
        nxt_st.aux = {SEL_PHASE_CHANNEL, EXT_FIELD_DETECTED, TX_ACTIVE, OSC_STABLE,
                      RX_DECODER_ENABLED, RX_RECEIVING, PEER_DETECT_MODE,
                      COLLISION_AVOID_DETECT_ACTIVE};

        // RQ10 RQ19 restore defaults overrides any write in the same cycle
        if (SET_DEFAULT)
        begin
            nxt_st.ctrl = wtad_pkg::RST_CTRL;
            nxt_st.cfg = wtad_pkg::RST_CFG;
            nxt_st.amp_ref = wtad_pkg::RST_REF;
            nxt_st.aux = wtad_pkg::RST_AUX;
            nxt_st.avg = wtad_pkg::RST_AVG;
            nxt_st.cyc = '0;
            nxt_st.step = 3'h0;
        end
    end

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            st_ff <= '0;
            st_ff.waitreq <= 1'b1;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign AVS_READDATA = {24'h000000, st_ff.rdata};
    assign AVS_WAITREQUEST = st_ff.waitreq;
    assign AMP_MEAS_REQ = st_ff.amp_req;
    assign PHASE_MEAS_REQ = st_ff.ph_req;
    assign WAKE_IRQ_TIMER = st_ff.irq_tmr;
    assign WAKE_IRQ_AMP = st_ff.irq_amp;
    assign WAKE_IRQ_PHASE = st_ff.irq_ph;
    assign AMP_AVERAGE = st_ff.avg;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);

    property p_rq1_bound;
        st_ff.cyc <= base_last;
    endproperty
    a_rq1_bound: assert property (p_rq1_bound) else $error("step counter beyond base step"); // RQ1

    property p_rq2_step;
        timer_run |-> st_ff.step <= period_code;
    endproperty
    a_rq2_step: assert property (p_rq2_step) else $error("step count beyond period code"); // RQ2

    property p_rq3_tmr;
        fire && st_ff.ctrl[wtad_pkg::CTRL_TMR_IRQ_BIT] |=> WAKE_IRQ_TIMER ##1 !WAKE_IRQ_TIMER;
    endproperty
    a_rq3_tmr: assert property (p_rq3_tmr) else $error("timer interrupt not one pulse"); // RQ3

    property p_rq4_req;
        AMP_MEAS_REQ |-> $past(fire) && $past(st_ff.ctrl[wtad_pkg::CTRL_AMP_CHK_BIT]);
    endproperty
    a_rq4_req: assert property (p_rq4_req) else $error("amplitude request without expiry"); // RQ4

    property p_rq5_req;
        fire && st_ff.ctrl[wtad_pkg::CTRL_PH_CHK_BIT] |=> PHASE_MEAS_REQ;
    endproperty
    a_rq5_req: assert property (p_rq5_req) else $error("phase request missing"); // RQ5

    property p_rq9_ref;
        AMP_MEAS_DONE && st_ff.ctrl[wtad_pkg::CTRL_AMP_CHK_BIT] && !st_ff.cfg[wtad_pkg::CFG_SRC_BIT]
        |=> WAKE_IRQ_AMP == ($past(abs_diff(AMP_MEAS_RESULT, st_ff.amp_ref)) > {4'h0, $past(amp_thr)});
    endproperty
    a_rq9_ref: assert property (p_rq9_ref) else $error("amplitude compare wrong"); // RQ9

    property p_rq7_excl;
        AMP_MEAS_DONE && st_ff.ctrl[wtad_pkg::CTRL_AMP_CHK_BIT] && amp_trig
        && !st_ff.cfg[wtad_pkg::CFG_INC_BIT] && !SET_DEFAULT |=> $stable(AMP_AVERAGE);
    endproperty
    a_rq7_excl: assert property (p_rq7_excl) else $error("excluded result changed average"); // RQ7

    property p_rq20_avg;
        AMP_MEAS_DONE && st_ff.ctrl[wtad_pkg::CTRL_AMP_CHK_BIT] && !amp_trig && !SET_DEFAULT
        |=> AMP_AVERAGE == avg_update($past(st_ff.avg), $past(AMP_MEAS_RESULT), $past(amp_wcode));
    endproperty
    a_rq20_avg: assert property (p_rq20_avg) else $error("average update wrong"); // RQ20

    property p_rq10_def;
        SET_DEFAULT |=> st_ff.ctrl == 8'h00 && st_ff.cfg == 8'h00 && st_ff.amp_ref == 8'h00
                        && st_ff.aux == 8'h00;
    endproperty
    a_rq10_def: assert property (p_rq10_def) else $error("defaults not restored"); // RQ10

    property p_rq12_efd;
        !SET_DEFAULT |=> st_ff.aux[6] == $past(EXT_FIELD_DETECTED);
    endproperty
    a_rq12_efd: assert property (p_rq12_efd) else $error("field detect not mirrored"); // RQ12

    property p_rq21_rsvd;
        bus_acc && AVS_READ && at_reg(AVS_ADDRESS, wtad_pkg::IDX_RSVD_A)
        |=> !AVS_WAITREQUEST && AVS_READDATA == 32'h00000000;
    endproperty
    a_rq21_rsvd: assert property (p_rq21_rsvd) else $error("reserved read not zero"); // RQ21

    // the average never steps past the newest result
    property p_rq20_toward;
        AMP_MEAS_DONE && st_ff.ctrl[wtad_pkg::CTRL_AMP_CHK_BIT] && !SET_DEFAULT
        |=> abs_diff(AMP_AVERAGE, $past(AMP_MEAS_RESULT))
            <= abs_diff($past(st_ff.avg), $past(AMP_MEAS_RESULT));
    endproperty
    a_rq20_toward: assert property (p_rq20_toward) else $error("average moved away"); // RQ20

    // rounding toward minus infinity allows one extra count downwards
    property p_rq8_weight;
        AMP_MEAS_DONE && st_ff.ctrl[wtad_pkg::CTRL_AMP_CHK_BIT] && !amp_trig && !SET_DEFAULT
        |=> 8'(abs_diff(AMP_AVERAGE, $past(st_ff.avg))
            - ($past(abs_diff(AMP_MEAS_RESULT, st_ff.avg))
               >> (wtad_pkg::AVG_SHIFT_BASE + int'($past(amp_wcode))))) <= 8'h01;
    endproperty
    a_rq8_weight: assert property (p_rq8_weight) else $error("average step off weight"); // RQ8

    property p_rq9_avg;
        AMP_MEAS_DONE && st_ff.ctrl[wtad_pkg::CTRL_AMP_CHK_BIT]
        && st_ff.cfg[wtad_pkg::CFG_SRC_BIT]
        |=> WAKE_IRQ_AMP == ($past(abs_diff(AMP_MEAS_RESULT, st_ff.avg)) > {4'h0, $past(amp_thr)});
    endproperty
    a_rq9_avg: assert property (p_rq9_avg) else $error("average compare wrong"); // RQ9

    property p_rq5_cmp;
        PHASE_MEAS_DONE && st_ff.ctrl[wtad_pkg::CTRL_PH_CHK_BIT]
        |=> WAKE_IRQ_PHASE == ($past(abs_diff(PHASE_MEAS_RESULT, PHASE_REFERENCE))
                               > {4'h0, $past(PHASE_DELTA_THRESHOLD)});
    endproperty
    a_rq5_cmp: assert property (p_rq5_cmp) else $error("phase compare wrong"); // RQ5

    // one cycle lag from the status pins to the display
    property p_rq11_aux;
        !SET_DEFAULT |=> st_ff.aux == $past({SEL_PHASE_CHANNEL, EXT_FIELD_DETECTED, TX_ACTIVE,
                         OSC_STABLE, RX_DECODER_ENABLED, RX_RECEIVING, PEER_DETECT_MODE,
                         COLLISION_AVOID_DETECT_ACTIVE});
    endproperty
    a_rq11_aux: assert property (p_rq11_aux) else $error("status display not mirrored"); // RQ11

    property p_rq21_wr;
        bus_acc && AVS_WRITE && at_reg(AVS_ADDRESS, wtad_pkg::IDX_RSVD_B) && !SET_DEFAULT
        |=> $stable(st_ff.ctrl) && $stable(st_ff.cfg) && $stable(st_ff.amp_ref);
    endproperty
    a_rq21_wr: assert property (p_rq21_wr) else $error("reserved write landed"); // RQ21

    property p_rq10_tmr;
        SET_DEFAULT |=> st_ff.cyc == '0 && st_ff.step == 3'h0 && AMP_AVERAGE == 8'h00;
    endproperty
    a_rq10_tmr: assert property (p_rq10_tmr) else $error("timer or average not cleared"); // RQ10

    c_tmr_irq: cover property (WAKE_IRQ_TIMER);
    c_amp_irq: cover property (WAKE_IRQ_AMP);
    c_ph_irq: cover property (WAKE_IRQ_PHASE);
    c_bus_rd: cover property (AVS_READ && !AVS_WAITREQUEST);
    c_avg_ref: cover property (AMP_MEAS_DONE && st_ff.cfg[wtad_pkg::CFG_SRC_BIT]);

endmodule : wtad_top

/* File: wtad_top_tb.sv */
`timescale 1ns/1ps
`define CHK(got, exp) \
    begin \
        samples_checked++; \
        if ((got) !== (exp)) \
        begin \
            fail_count++; \
            $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp); \
        end \
    end

module wtad_top_tb;
    // short steps keep every period within a few hundred cycles
    localparam int LS = 20;
    localparam int SS = 5;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic rd = 1'b0, wr = 1'b0, set_def = 1'b0, amp_done = 1'b0, ph_done = 1'b0;
    logic [7:0] adr = 8'h00, st = 8'h00, amp_res = 8'h00, ph_res = 8'h00, ph_ref = 8'h00;
    logic [3:0] ph_thr = 4'h0;
    logic [3:0] be = 4'h1;
    logic [31:0] wdata = 32'h0;
    logic [31:0] readdata;
    logic waitreq, irq_t, irq_a, irq_p, req_a, req_p;
    logic [7:0] avg;
    int fail_count = 0;
    int samples_checked = 0;

    always #12.5 clk = ~clk;

    wtad_top #(.LONG_STEP_CYCLES(LS), .SHORT_STEP_CYCLES(SS)) i_dut (
        .CLK(clk), .RST_N(rst_n), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
        .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be), .AVS_READDATA(readdata),
        .AVS_WAITREQUEST(waitreq), .SET_DEFAULT(set_def), .SEL_PHASE_CHANNEL(st[7]),
        .EXT_FIELD_DETECTED(st[6]), .TX_ACTIVE(st[5]), .OSC_STABLE(st[4]),
        .RX_DECODER_ENABLED(st[3]), .RX_RECEIVING(st[2]), .PEER_DETECT_MODE(st[1]),
        .COLLISION_AVOID_DETECT_ACTIVE(st[0]), .AMP_MEAS_REQ(req_a),
        .AMP_MEAS_DONE(amp_done), .AMP_MEAS_RESULT(amp_res), .PHASE_MEAS_REQ(req_p),
        .PHASE_MEAS_DONE(ph_done), .PHASE_MEAS_RESULT(ph_res),
        .PHASE_DELTA_THRESHOLD(ph_thr), .PHASE_REFERENCE(ph_ref), .WAKE_IRQ_TIMER(irq_t),
        .WAKE_IRQ_AMP(irq_a), .WAKE_IRQ_PHASE(irq_p), .AMP_AVERAGE(avg)
    );

    ////////////////////////////////////////
    task summarize;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : summarize

    // request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic w, input logic [5:0] idx, input logic [7:0] d,
                       output logic [7:0] q);
        int n;
        @(posedge clk);
        adr <= {idx, 2'b00};
        rd <= !w;
        wr <= w;
        wdata <= {24'($urandom), d};
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (waitreq !== 1'b0 && n < 20);
        q = readdata[7:0];
        rd <= 1'b0;
        wr <= 1'b0;
        if (waitreq !== 1'b0)
        begin
            fail_count++;
            summarize();
        end
    endtask : bus

    task automatic rdchk(input logic [5:0] idx, input logic [7:0] e);
        logic [7:0] q;
        bus(1'b0, idx, 8'h00, q);
        `CHK(q, e)
    endtask : rdchk

    task automatic wrr(input logic [5:0] idx, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, idx, d, q);
    endtask : wrr

    function automatic logic [7:0] adiff(input logic [7:0] a, input logic [7:0] b);
        return (a > b) ? a - b : b - a;
    endfunction : adiff

    function automatic logic [7:0] avg_next(input logic [7:0] a, input logic [7:0] r,
                                            input logic [1:0] w);
        logic signed [8:0] d;
        d = $signed({1'b0, r}) - $signed({1'b0, a});
        d = d >>> (2 + w);
        return a + d[7:0];
    endfunction : avg_next

    ////////////////////////////////////////
    initial
    begin
        logic [5:0] idxs [6];
        logic [7:0] v, c, r, ea, base, pr;
        int n, ex;
        logic hit, ta, tp;
        idxs = '{wtad_pkg::IDX_RSVD_A, wtad_pkg::IDX_RSVD_B, wtad_pkg::IDX_AUX,
                 wtad_pkg::IDX_CTRL, wtad_pkg::IDX_CFG, wtad_pkg::IDX_REF};
        ea = 8'h00;
        void'($urandom(43));
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 6; i++)
            rdchk(idxs[i], 8'h00);
        rdchk(6'h00, 8'h00);
        $display("test reset_values done");

        repeat (8)
        begin
            v = 8'($urandom);
            wrr(wtad_pkg::IDX_CTRL, v);
            rdchk(wtad_pkg::IDX_CTRL, v & wtad_pkg::CTRL_WR_MASK);
            wrr(wtad_pkg::IDX_CFG, ~v);
            rdchk(wtad_pkg::IDX_CFG, ~v);
            wrr(wtad_pkg::IDX_REF, v ^ 8'h3c);
            rdchk(wtad_pkg::IDX_REF, v ^ 8'h3c);
            // a write with byte lane 0 disabled must not land
            be <= 4'h0;
            wrr(wtad_pkg::IDX_REF, ~v);
            be <= 4'h1;
            rdchk(wtad_pkg::IDX_REF, v ^ 8'h3c);
            wrr(wtad_pkg::IDX_RSVD_A, v);
            rdchk(wtad_pkg::IDX_RSVD_A, 8'h00);
            wrr(wtad_pkg::IDX_RSVD_B, v);
            rdchk(wtad_pkg::IDX_RSVD_B, 8'h00);
        end
        wrr(wtad_pkg::IDX_CTRL, 8'h00);
        wrr(wtad_pkg::IDX_CFG, 8'h00);
        $display("test register_access done");

        repeat (8)
        begin
            st <= 8'($urandom);
            wrr(wtad_pkg::IDX_AUX, ~st);
            rdchk(wtad_pkg::IDX_AUX, st);
        end
        $display("test aux_display done");

        // every range and period code, with a random non-empty action mix
        for (int k = 0; k < 16; k++)
        begin
            v = {k[0], k[3:1], 3'($urandom_range(1, 7)), 1'b0};
            wrr(wtad_pkg::IDX_CTRL, v);
            ex = (int'(v[6:4]) + 1) * (v[7] ? SS : LS);
            hit = 1'b0;
            for (n = 0; n < 400 && !hit; n++)
            begin
                @(posedge clk);
                hit = ((irq_t | req_a | req_p) === 1'b1);
            end
            if (!hit)
            begin
                fail_count++;
                summarize();
            end
            hit = 1'b0;
            n = 0;
            while (!hit && n < 400)
            begin
                @(posedge clk);
                n++;
                hit = ((irq_t | req_a | req_p) === 1'b1);
            end
            if (!hit)
            begin
                fail_count++;
                summarize();
            end
            `CHK(n, ex)
            `CHK({irq_t, req_a, req_p}, v[3:1])
        end
        wrr(wtad_pkg::IDX_CTRL, 8'h00);
        $display("test wake_timer done");

        repeat (60)
        begin
            c = 8'($urandom);
            r = 8'($urandom);
            v = {5'h00, 2'($urandom), 1'b0};
            wrr(wtad_pkg::IDX_CFG, c);
            wrr(wtad_pkg::IDX_REF, r);
            wrr(wtad_pkg::IDX_CTRL, v);
            base = c[0] ? ea : r;
            @(posedge clk);
            amp_done <= 1'b1;
            amp_res <= base + 8'($urandom_range(0, 40)) - 8'd20;
            ph_done <= 1'b1;
            // the result must sit near the new reference, not the old one
            pr = 8'($urandom);
            ph_ref <= pr;
            ph_res <= pr + 8'($urandom_range(0, 30)) - 8'd15;
            ph_thr <= 4'($urandom);
            @(posedge clk);
            amp_done <= 1'b0;
            ph_done <= 1'b0;
            @(negedge clk);
            ta = v[2] && (adiff(amp_res, base) > c[7:4]);
            tp = v[1] && (adiff(ph_res, ph_ref) > ph_thr);
            if (v[2] && (!ta || c[3]))
                ea = avg_next(ea, amp_res, c[2:1]);
            `CHK(irq_a, ta)
            `CHK(irq_p, tp)
            `CHK(avg, ea)
        end
        $display("test measure_compare done");

        wrr(wtad_pkg::IDX_CFG, 8'hff);
        wrr(wtad_pkg::IDX_REF, 8'h5a);
        wrr(wtad_pkg::IDX_CTRL, 8'hfe);
        st <= 8'h00;
        set_def <= 1'b1;
        @(posedge clk);
        set_def <= 1'b0;
        rdchk(wtad_pkg::IDX_CTRL, 8'h00);
        rdchk(wtad_pkg::IDX_CFG, 8'h00);
        rdchk(wtad_pkg::IDX_REF, 8'h00);
        rdchk(wtad_pkg::IDX_AUX, 8'h00);
        `CHK(avg, 8'h00)
        $display("test set_default done");
        summarize();
    end
endmodule : wtad_top_tb
